// >>> hw/fidc_cycle.sv
// One flash bus cycle, read or write, with phased enables.
// Assumes the device needs setup, strobe and hold phases of a fixed cycle count.
`timescale 1ns/1ns
`default_nettype none
module fidc_cycle
    import fidc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic wr,
    input wire logic [21:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_i,
    output logic [21:0] fa,
    output logic [7:0] dq_o,
    output logic dq_oe,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [7:0] rdata,
    output logic done
);
    // Phase states, one-hot.
    typedef enum logic [3:0] {
        FIDC_C_IDLE = 4'b0001,
        FIDC_C_SETUP = 4'b0010,
        FIDC_C_STROBE = 4'b0100,
        FIDC_C_HOLD = 4'b1000
    } fidc_cyc_t;
    fidc_cyc_t state; // Current phase.
    logic [FIDC_CNT_W-1:0] cnt; // Cycles left in the phase.
    localparam logic [FIDC_CNT_W-1:0] PHASE = FIDC_CNT_W'(FIDC_PHASE_CYC - 1);

    // Phase sequencer; address and data are set before the strobe falls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= FIDC_C_IDLE;
            cnt <= '0;
            fa <= '0;
            dq_o <= '0;
            dq_oe <= 1'b0;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            rdata <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                FIDC_C_IDLE: begin
                    if (start) begin
                        fa <= addr;
                        dq_o <= wdata;
                        dq_oe <= wr;
                        cnt <= PHASE;
                        state <= FIDC_C_SETUP;
                    end
                end
                FIDC_C_SETUP: begin
                    if (cnt == '0) begin
                        // Write: chip and write low with output high; read: output low.
                        ce_n <= 1'b0;
                        we_n <= !wr;
                        oe_n <= wr;
                        cnt <= PHASE;
                        state <= FIDC_C_STROBE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                FIDC_C_STROBE: begin
                    // Strobe held several cycles so it is never a short glitch.
                    if (cnt == '0) begin
                        if (!wr) begin
                            rdata <= dq_i;
                        end
                        // Both rise together; data stays driven through hold.
                        ce_n <= 1'b1;
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        cnt <= PHASE;
                        state <= FIDC_C_HOLD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                FIDC_C_HOLD: begin
                    if (cnt == '0) begin
                        dq_oe <= 1'b0;
                        done <= 1'b1;
                        state <= FIDC_C_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= FIDC_C_IDLE;
                end
            endcase
        end
    end

    // Output enable must never overlap a driven data bus.
    a_no_contention: assert property (@(posedge pclk) disable iff (!presetn)
        !(dq_oe && !oe_n)) else $error("data driven while output enabled");
    // A write strobe lasts the full phase.
    a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(we_n) |-> !we_n [*5]) else $error("write strobe too short");
    // Address stays stable across the whole strobe.
    a_addr_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !ce_n |-> $stable(fa)) else $error("address moved during strobe");
endmodule : fidc_cycle
`default_nettype wire

// >>> hw/fidc_host.sv
// Host controller driving the flash pins for identification and protection work.
// Assumes software on APB; the device answers reads within one strobe phase.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module fidc_host
    import fidc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [21:0] flash_addr,
    input wire logic [7:0] data_bus_i,
    output logic [7:0] data_bus_o,
    output logic data_bus_oe,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic id_select_hv,
    output logic reset_hv
);
    // Sequencer states, one-hot.
    typedef enum logic [5:0] {
        FIDC_IDLE = 6'b000001,
        FIDC_ISSUE = 6'b000010,
        FIDC_WAIT = 6'b000100,
        FIDC_CHECK = 6'b001000,
        FIDC_FAIL = 6'b010000,
        FIDC_DONE = 6'b100000
    } fidc_state_t;
    fidc_state_t state; // Main sequencer state.
    logic [2:0] op; // Operation being run.
    logic [21:0] addr_reg; // Target address.
    logic [7:0] wdata_reg; // Target write data.
    logic [7:0] rdata_reg; // Last byte read.
    logic busy; // Operation in progress.
    logic fail; // Guarded operation refused.
    logic parity_err; // Identification byte parity bad.
    logic in_id_mode; // Device left in identification mode.
    logic [2:0] step; // Step within a sequence.
    logic cyc_start; // Start one bus cycle.
    logic cyc_wr; // Cycle is a write.
    logic [21:0] cyc_addr; // Cycle address.
    logic [7:0] cyc_wdata; // Cycle data.
    logic [7:0] cyc_rdata; // Data read by the cycle.
    logic cyc_done; // Cycle finished.
    logic [2:0] last_step; // Final step index of the current op.
    logic apb_wr; // Register write in access phase.
    logic bad_parity; // Read byte has even parity.

    assign apb_wr = psel && penable && pwrite;
    assign bad_parity = !(^cyc_rdata);

    // Step programs: one read, write or reset cycle, or unlock, unlock, command, then read.
    always_comb begin
        cyc_wr = 1'b1;
        cyc_addr = FIDC_UNLOCK1_ADDR;
        cyc_wdata = FIDC_UNLOCK1_DATA;
        last_step = 3'd0;
        case (op)
            FIDC_OP_READ, FIDC_OP_HV_ID: begin
                cyc_wr = 1'b0;
                cyc_addr = addr_reg;
            end
            FIDC_OP_WRITE: begin
                cyc_addr = addr_reg;
                cyc_wdata = wdata_reg;
            end
            FIDC_OP_RESET: begin
                // Reset command leaves identification or timeout state.
                cyc_wdata = FIDC_RESET_CMD;
            end
            FIDC_OP_ID_ENTER, FIDC_OP_GUARDED: begin
                last_step = 3'd3;
                if (step == 3'd1) begin
                    cyc_addr = FIDC_UNLOCK2_ADDR;
                    cyc_wdata = FIDC_UNLOCK2_DATA;
                end else if (step == 3'd2) begin
                    cyc_wdata = FIDC_ID_CMD;
                end else if (step == 3'd3) begin
                    // Read the target address, or for the guarded op the group status byte at low address two.
                    cyc_wr = 1'b0;
                    cyc_addr = (op == FIDC_OP_GUARDED) ?
                        {addr_reg[21:8], FIDC_PROT_LOW} : addr_reg;
                end
            end
            default: begin
                cyc_wr = 1'b0;
            end
        endcase
    end

    // Main sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= FIDC_IDLE;
            step <= '0;
            cyc_start <= 1'b0;
            busy <= 1'b0;
            fail <= 1'b0;
            parity_err <= 1'b0;
            rdata_reg <= '0;
            in_id_mode <= 1'b0;
        end else begin
            cyc_start <= 1'b0;
            case (state)
                FIDC_IDLE: begin
                    if (apb_wr && paddr == FIDC_CTRL_OFS && pwdata[FIDC_GO_BIT]) begin
                        busy <= 1'b1;
                        fail <= 1'b0;
                        parity_err <= 1'b0;
                        step <= '0;
                        state <= FIDC_ISSUE;
                    end
                end
                FIDC_ISSUE: begin
                    cyc_start <= 1'b1;
                    state <= FIDC_WAIT;
                end
                FIDC_WAIT: begin
                    if (cyc_done) begin
                        if (step == last_step) begin
                            rdata_reg <= cyc_rdata;
                            state <= FIDC_CHECK;
                        end else begin
                            step <= step + 3'd1;
                            state <= FIDC_ISSUE;
                        end
                    end
                end
                FIDC_CHECK: begin
                    state <= FIDC_DONE;
                    if (op == FIDC_OP_ID_ENTER || op == FIDC_OP_GUARDED) begin
                        in_id_mode <= 1'b1;
                    end
                    if (op == FIDC_OP_RESET) begin
                        in_id_mode <= 1'b0;
                    end
                    // Pin identification reads of maker and part need odd parity on the top bit.
                    if (op == FIDC_OP_HV_ID && addr_reg[1] == 1'b0 && bad_parity) begin
                        parity_err <= 1'b1;
                    end
                    // A protected group without temporary unprotect is refused.
                    if (op == FIDC_OP_GUARDED && rdata_reg == FIDC_PROTECTED_VAL && !reset_hv) begin
                        fail <= 1'b1;
                        state <= FIDC_FAIL;
                    end
                end
                FIDC_FAIL: begin
                    state <= FIDC_DONE;
                end
                FIDC_DONE: begin
                    busy <= 1'b0;
                    state <= FIDC_IDLE;
                end
                default: begin
                    state <= FIDC_IDLE;
                end
            endcase
        end
    end

    // Captured operation and target registers, writable only while idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= FIDC_OP_READ;
            addr_reg <= '0;
            wdata_reg <= '0;
            id_select_hv <= 1'b0;
            reset_hv <= 1'b0;
        end else if (apb_wr && state == FIDC_IDLE) begin
            if (paddr == FIDC_CTRL_OFS) begin
                op <= pwdata[FIDC_OP_LSB +: 3];
                // High voltage on the id line selects pin identification.
                id_select_hv <= pwdata[FIDC_HV_ID_BIT];
                // Elevated reset pin opens protected groups temporarily.
                reset_hv <= pwdata[FIDC_HV_RST_BIT];
            end else if (paddr == FIDC_ADDR_OFS) begin
                addr_reg <= pwdata[21:0];
            end else if (paddr == FIDC_WDATA_OFS) begin
                wdata_reg <= pwdata[7:0];
            end
        end
    end

    // APB read data and ready; zero wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    FIDC_CTRL_OFS: prdata <= {26'h0, reset_hv, id_select_hv, op, 1'b0};
                    FIDC_ADDR_OFS: prdata <= {10'h0, addr_reg};
                    FIDC_WDATA_OFS: prdata <= {24'h0, wdata_reg};
                    FIDC_STAT_OFS: prdata <= {28'h0, in_id_mode, parity_err, fail, busy};
                    FIDC_RDATA_OFS: prdata <= {24'h0, rdata_reg};
                    default: prdata <= FIDC_UNMAPPED;
                endcase
            end
        end
    end

    // Pin cycle engine.
    fidc_cycle u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .start(cyc_start),
        .wr(cyc_wr),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .dq_i(data_bus_i),
        .fa(flash_addr),
        .dq_o(data_bus_o),
        .dq_oe(data_bus_oe),
        .ce_n(ce_n),
        .we_n(we_n),
        .oe_n(oe_n),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );

    // A protected status without unprotect always ends as a failure.
    a_guard_fail: assert property (@(posedge pclk) disable iff (!presetn)
        (state == FIDC_CHECK && op == FIDC_OP_GUARDED && rdata_reg == FIDC_PROTECTED_VAL
         && !reset_hv) |=> (fail && state == FIDC_FAIL)) else $error("refusal missed");
    // Temporary unprotect never reports a refusal.
    a_unprot_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (state == FIDC_CHECK && reset_hv) |=> !$rose(fail)) else $error("refused under unprotect");
    // Reset command clears identification mode.
    a_reset_exit: assert property (@(posedge pclk) disable iff (!presetn)
        (state == FIDC_CHECK && op == FIDC_OP_RESET) |=> !in_id_mode) else $error("id mode kept");
    // Identification entry sets the mode flag.
    a_id_enter: assert property (@(posedge pclk) disable iff (!presetn)
        (state == FIDC_CHECK && op == FIDC_OP_ID_ENTER) |=> in_id_mode) else $error("id mode not set");
    // Parity flag rises only from an even-parity id byte.
    a_parity_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(parity_err) |-> ($past(op) == FIDC_OP_HV_ID && !(^$past(rdata_reg))))
        else $error("bad parity flag");
    // Busy clears within three cycles of finishing checks.
    a_busy_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (state == FIDC_CHECK) |-> ##[1:3] !busy) else $error("busy stuck");
endmodule : fidc_host
`default_nettype wire

// >>> hw/fidc_pkg.sv
// Constants shared by the flash identification and protection host controller.
// Assumes a single 125 MHz clock and an APB register port of 32-bit aligned words.
// Summary of operation
// - High voltage id reads maker, then part.
// - Command mode gives identification without high voltage.
// - Elevated reset pin unprotects protected groups.
// - Host writes reset after timeout or identification.
// - Write only with chip, write low, output high.
// - Host leaves identification by reset command.
package fidc_pkg;
    // Register byte offsets on APB.
    localparam logic [7:0] FIDC_CTRL_OFS = 8'h00;
    localparam logic [7:0] FIDC_ADDR_OFS = 8'h04;
    localparam logic [7:0] FIDC_WDATA_OFS = 8'h08;
    localparam logic [7:0] FIDC_STAT_OFS = 8'h0C;
    localparam logic [7:0] FIDC_RDATA_OFS = 8'h10;
    // Control field positions; a write with go set starts an operation.
    localparam int FIDC_GO_BIT = 0;
    localparam int FIDC_OP_LSB = 1;
    localparam int FIDC_HV_ID_BIT = 4;
    localparam int FIDC_HV_RST_BIT = 5;
    // Operation codes.
    localparam logic [2:0] FIDC_OP_READ = 3'h0;
    localparam logic [2:0] FIDC_OP_WRITE = 3'h1;
    localparam logic [2:0] FIDC_OP_ID_ENTER = 3'h2;
    localparam logic [2:0] FIDC_OP_RESET = 3'h3;
    localparam logic [2:0] FIDC_OP_HV_ID = 3'h4;
    localparam logic [2:0] FIDC_OP_GUARDED = 3'h5;
    // Command sequence addresses and data.
    localparam logic [21:0] FIDC_UNLOCK1_ADDR = 22'h000555;
    localparam logic [21:0] FIDC_UNLOCK2_ADDR = 22'h0002AA;
    localparam logic [7:0] FIDC_UNLOCK1_DATA = 8'hAA;
    localparam logic [7:0] FIDC_UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] FIDC_ID_CMD = 8'h90;
    localparam logic [7:0] FIDC_RESET_CMD = 8'hF0;
    localparam logic [7:0] FIDC_MAKER_LOW = 8'h00;
    localparam logic [7:0] FIDC_PART_LOW = 8'h01;
    localparam logic [7:0] FIDC_PROT_LOW = 8'h02;
    localparam logic [7:0] FIDC_PROTECTED_VAL = 8'h01;
    localparam int FIDC_GROUP_LSB = 18;
    // Bus timing: each strobe phase held this long.
    localparam int FIDC_PHASE_NS = 40;
    localparam int FIDC_CLK_NS = 8;
    localparam int FIDC_PHASE_CYC = (FIDC_PHASE_NS + FIDC_CLK_NS - 1) / FIDC_CLK_NS;
    localparam int FIDC_CNT_W = 4;
    localparam logic [31:0] FIDC_UNMAPPED = 32'h00000000;
endpackage : fidc_pkg

// >>> test/fidc_flash_model.sv
// Behavioural model of the parallel flash seen at the far side of the host controller.
// Assumes the host drives the strobes and a resolved data bus; the model has no clock.
`timescale 1ns/1ns
`default_nettype none
module fidc_flash_model
    import fidc_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h0B, // Arbitrary value, odd parity on bit 7.
    parameter logic [7:0] PART_CODE = 8'h0D, // Arbitrary value, odd parity on bit 7.
    parameter logic [15:0] PROT_MASK = 16'h8001 // Groups 0 and 15 leave the factory protected.
)(
    input wire logic [21:0] fa,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic id_hv,
    input wire logic rst_hv
);
    typedef enum logic [1:0] {FIDC_ARRAY, FIDC_UNL1, FIDC_UNL2, FIDC_IDM} fidc_mode_t;
    fidc_mode_t mode = FIDC_ARRAY; // Power-up lands in array read whatever the strobes do.
    realtime fell_at = 0.0; // Time at which the latest write strobe pair went low.
    logic [21:0] last_wa = 22'h000000; // Address of the latest write cycle.
    logic [7:0] last_wd = 8'h00; // Data of the latest write cycle.
    logic [7:0] held = 8'h00; // Last byte driven, inverted once the bus is released.
    logic armed = 1'b0; // A legal write cycle is open.
    int viol = 0; // Write strobes seen while the outputs were enabled.
    logic [7:0] val; // Byte the device would present.
    logic [7:0] grp; // Protection byte of the addressed group.

    // Stored protection never changes; the elevated reset pin does not touch it.
    assign grp = PROT_MASK[fa[21:18]] ? 8'h01 : 8'h00;

    // Chooses what a read returns in each mode.
    always_comb begin
        // Array content pattern; no sector is ever suspended, so every read outside identification sees it.
        val = fa[7:0] ^ fa[15:8] ^ 8'h3C;
        if (id_hv && !fa[6]) begin
            case (fa[1:0])
                2'h0: val = MAKER_CODE;
                2'h1: val = PART_CODE;
                2'h2: val = grp;
                default: val = 8'h00;
            endcase
        end else if (mode == FIDC_IDM) begin
            case (fa[7:0])
                8'h00: val = MAKER_CODE;
                8'h01: val = PART_CODE;
                8'h02: val = grp;
                default: val = 8'h00;
            endcase
        end
    end

    // Drives only while selected and read-enabled, otherwise a value the host must not trust.
    assign dq_o = (!ce_n && !oe_n) ? val : ~held;
    always @(posedge oe_n) held <= val;

    // Address is taken at the later falling edge of the two enables.
    always @(negedge ce_n or negedge we_n) begin
        if (!ce_n && !we_n) begin
            last_wa <= fa;
            fell_at = $realtime;
            armed <= oe_n;
            if (!oe_n) viol++;
        end
    end

    // Data is taken at the earlier rising edge and steps the command sequence.
    always @(posedge ce_n or posedge we_n) begin
        // A strobe shorter than 5 ns is a glitch and starts no write.
        if (armed && ($realtime - fell_at) >= 5.0) begin
            armed <= 1'b0;
            last_wd <= dq_i;
            if (dq_i == FIDC_RESET_CMD) mode <= FIDC_ARRAY;
            else if (mode == FIDC_UNL1)
                mode <= (last_wa == FIDC_UNLOCK2_ADDR && dq_i == FIDC_UNLOCK2_DATA) ? FIDC_UNL2 : FIDC_ARRAY;
            else if (mode == FIDC_UNL2)
                mode <= (last_wa == FIDC_UNLOCK1_ADDR && dq_i == FIDC_ID_CMD) ? FIDC_IDM : FIDC_ARRAY;
            else if (last_wa == FIDC_UNLOCK1_ADDR && dq_i == FIDC_UNLOCK1_DATA) mode <= FIDC_UNL1;
            else if (mode != FIDC_IDM) mode <= FIDC_ARRAY;
        end
    end
endmodule : fidc_flash_model
`default_nettype wire

// >>> test/tb_fidc_host.sv
// Self-checking bench for the flash identification and protection host controller.
// Assumes the flash model beside it and a 125 MHz APB clock.
`timescale 1ns/1ns
`default_nettype none
module tb_fidc_host;
    import fidc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00; // APB byte address.
    logic [31:0] pwdata = 32'h00000000; // APB write data.
    logic [31:0] prdata;
    logic pready, pslverr, data_bus_oe, ce_n, we_n, oe_n, id_select_hv, reset_hv;
    logic [21:0] flash_addr;
    logic [7:0] data_bus_o, flash_dq;
    wire logic [7:0] dq_wire; // Resolved data bus level.
    int mismatches = 0;
    int total_checks = 0;
    localparam logic [7:0] MAKER = 8'h0B; // Same arbitrary code as the model.
    localparam logic [7:0] PART = 8'h0D; // Same arbitrary code as the model.
    assign dq_wire = data_bus_oe ? data_bus_o : flash_dq;

    fidc_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(flash_addr), .data_bus_i(dq_wire), .data_bus_o(data_bus_o),
        .data_bus_oe(data_bus_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .id_select_hv(id_select_hv), .reset_hv(reset_hv));
    fidc_flash_model u_flash (.fa(flash_addr), .dq_i(dq_wire), .dq_o(flash_dq), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .id_hv(id_select_hv), .rst_hv(reset_hv));

    // Clock toggles every half period of 4 ns.
    always #4 pclk = ~pclk;

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer: setup, then access until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Register write wrapper.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    // Starts one operation and polls status until it is idle; poke rewrites ADDR while busy.
    task automatic run_op(input logic [2:0] op, input logic [21:0] a, input logic [7:0] d,
        input logic hvid, input logic hvrst, input logic poke, output logic [31:0] st);
        int n;
        wr(FIDC_ADDR_OFS, {10'h000, a});
        wr(FIDC_WDATA_OFS, {24'h000000, d});
        wr(FIDC_CTRL_OFS, {26'h0, hvrst, hvid, op, 1'b1});
        if (poke) wr(FIDC_ADDR_OFS, 32'h003FFFFF);
        n = 0;
        do begin
            apb(1'b0, FIDC_STAT_OFS, 32'h0, st);
            n++;
        end while (st[0] !== 1'b0 && n < 200);
        check("busy", 32'h0, {31'h0, st[0]});
    endtask : run_op

    // Reset levels, idle status and an unmapped read.
    task automatic t_reset();
        logic [31:0] q;
        check("strobes", 32'h7, {29'h0, ce_n, we_n, oe_n});
        check("hv pins", 32'h0, {30'h0, id_select_hv, reset_hv});
        apb(1'b0, FIDC_STAT_OFS, 32'h0, q);
        check("status", 32'h0, q);
        apb(1'b0, 8'h20, 32'h0, q);
        check("unmapped", FIDC_UNMAPPED, q);
        check("slverr", 32'h0, {31'h0, pslverr});
        $display("t_reset done");
    endtask : t_reset

    // Identification by the elevated address line or by command, then back to array.
    task automatic t_ident(input logic cmd);
        logic [21:0] ad[5] = '{22'h000000, 22'h000001, 22'h000002, 22'h040002, 22'h3C0002};
        logic [7:0] ex[5] = '{MAKER, PART, 8'h01, 8'h00, 8'h01};
        logic [31:0] st, q;
        for (int i = 0; i < 5; i++) begin
            run_op(cmd ? FIDC_OP_ID_ENTER : FIDC_OP_HV_ID, ad[i], 8'h00, !cmd, 1'b0, 1'b0, st);
            apb(1'b0, FIDC_RDATA_OFS, 32'h0, q);
            check("id byte", {24'h0, ex[i]}, {24'h0, q[7:0]});
            check("parity error", 32'h0, {31'h0, st[2]});
            check("id mode", {31'h0, cmd}, {31'h0, st[3]});
            check("id line", {31'h0, !cmd}, {31'h0, id_select_hv});
        end
        run_op(FIDC_OP_RESET, 22'h000000, 8'h00, 1'b0, 1'b0, 1'b0, st);
        check("id mode left", 32'h0, {31'h0, st[3]});
        check("device mode", 32'h0, {30'h0, u_flash.mode});
        run_op(FIDC_OP_READ, 22'h123456, 8'h00, 1'b0, 1'b0, 1'b0, st);
        apb(1'b0, FIDC_RDATA_OFS, 32'h0, q);
        check("array byte", {24'h0, 8'h56 ^ 8'h34 ^ 8'h3C}, {24'h0, q[7:0]});
        $display("t_ident done");
    endtask : t_ident

    // Guarded check on protected and unprotected groups, with and without unprotect.
    task automatic t_guard();
        logic [21:0] ad[4] = '{22'h000000, 22'h000000, 22'h040000, 22'h3C0000};
        logic hv[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        logic fl[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic [31:0] st;
        for (int i = 0; i < 4; i++) begin
            run_op(FIDC_OP_GUARDED, ad[i], 8'h00, 1'b0, hv[i], 1'b0, st);
            check("fail flag", {31'h0, fl[i]}, {31'h0, st[1]});
            check("reset pin", {31'h0, hv[i]}, {31'h0, reset_hv});
        end
        // A pin read with line 6 high, the device still in identification mode, returns 0x00 of even parity, which is flagged.
        run_op(FIDC_OP_HV_ID, 22'h000041, 8'h00, 1'b1, 1'b0, 1'b0, st);
        check("parity flag", 32'h1, {31'h0, st[2]});
        run_op(FIDC_OP_RESET, 22'h000000, 8'h00, 1'b0, 1'b0, 1'b0, st);
        check("device mode", 32'h0, {30'h0, u_flash.mode});
        $display("t_guard done");
    endtask : t_guard

    // Single write cycles, one with ADDR rewritten while busy.
    task automatic t_write();
        logic [31:0] st;
        run_op(FIDC_OP_WRITE, 22'h2AB5C3, 8'hA5, 1'b0, 1'b0, 1'b0, st);
        check("write addr", 32'h002AB5C3, {10'h0, u_flash.last_wa});
        check("write data", 32'h000000A5, {24'h0, u_flash.last_wd});
        run_op(FIDC_OP_WRITE, 22'h001234, 8'h5A, 1'b0, 1'b0, 1'b1, st);
        check("busy refusal", 32'h00001234, {10'h0, u_flash.last_wa});
        check("write data", 32'h0000005A, {24'h0, u_flash.last_wd});
        check("output clash", 32'h0, u_flash.viol);
        $display("t_write done");
    endtask : t_write

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Main sequence.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ident(1'b0);
        t_ident(1'b1);
        t_guard();
        t_write();
        wrap_up();
    end

    // Watchdog well beyond the twelve hundred or so cycles the tests need.
    initial begin
        #(8 * 40000);
        mismatches++;
        wrap_up();
    end
endmodule : tb_fidc_host
`default_nettype wire
